// [dtsr_cfg.svh]
// constants for the debug trace status readout block
// assumes inclusion by dtsr_seq and dtsr_top
`ifndef DTSR_CFG_SVH
`define DTSR_CFG_SVH
`define DTSR_STATUS_OFS 8'h21
`define DTSR_INFO_OFS 8'h22
`define DTSR_CNT_OFS 8'h23
`define DTSR_CTRL_OFS 8'h20
`define DTSR_TBH_OFS 8'h24
`define DTSR_TBL_OFS 8'h26
`define DTSR_FULL_BIT 7
`define DTSR_EXT_BIT 6
`define DTSR_ARM_BIT 7
`define DTSR_SSF_DISARMED 3'h0
`define DTSR_SSF_FIRST 3'h1
`define DTSR_SSF_FINAL 3'h4
`define DTSR_LINES 64
`endif

// [dtsr_host.sv]
// reader model: register strobes of the trace readout block
// assumes requests launched at the falling edge of ref_clk
`timescale 1ns/10ps
module dtsr_host (
  input wire logic ref_clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic reg_word,
  output logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_word = 1'b0;
    reg_wdata = 16'h0000;
  end
  // released address and data lines invert so a stale value never passes as held
  task automatic drop();
    @(negedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    reg_addr <= ~reg_addr;
    reg_wdata <= ~reg_wdata;
  endtask
  // unlock is an aligned word write while disarmed
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
                    input logic w);
    @(negedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_word <= w;
    drop();
  endtask
  // meant for a disarmed, traced, unsecured buffer
  task automatic rd(input logic [7:0] a, input logic w,
                    output logic [15:0] d);
    @(negedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_word <= w;
    drop();
    @(negedge ref_clk);
    d = reg_rdata;
  endtask
endmodule

// [dtsr_mem.sv]
// trace line store, 64 lines of 64 bits plus 8 info bits
// assumes one write strobe per captured line
`timescale 1ns/10ps
module dtsr_mem #(
  parameter int LINES = 64,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [71:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [71:0] rd_data
);
  logic [71:0] mem [LINES];
  initial begin
    if (LINES != (1 << AW)) $error("depth must be a power of two");
  end
  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  assign rd_data = mem[rd_addr];
endmodule

// [dtsr_pkg.sv]
// types for the debug trace status readout block
// assumes dtsr_cfg.svh constants
package dtsr_pkg;
  typedef enum logic [1:0] {DTSR_IDLE, DTSR_ARMED, DTSR_DONE} dtsr_phase_t;
endpackage

// [dtsr_seq.sv]
// state sequencer flag field keeper
// assumes single-cycle arm, disarm, trigger and advance strobes
`timescale 1ns/10ps
`include "dtsr_cfg.svh"
module dtsr_seq (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic arm_set,
  input wire logic sw_disarm,
  input wire logic trig_end,
  input wire logic adv,
  output logic [2:0] state_r
);
  logic [2:0] state_nxt;
  always_comb begin
    state_nxt = state_r;
    if (arm_set) begin
      state_nxt = `DTSR_SSF_FIRST;
    end else if (trig_end) begin
      state_nxt = `DTSR_SSF_DISARMED;
    end else if (sw_disarm) begin
      state_nxt = state_r;
    end else if (adv && state_r != `DTSR_SSF_DISARMED &&
                 state_r < `DTSR_SSF_FINAL) begin
      state_nxt = state_r + 3'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_r <= 3'h0;
    end else begin
      state_r <= state_nxt;
    end
  end
  chk_arm_first: assert property (@(posedge ref_clk) disable iff (sys_rst)
    arm_set |=> state_r == 3'h1) else $error("arm not first state");
  chk_trig_clear: assert property (@(posedge ref_clk) disable iff (sys_rst)
    trig_end && !arm_set |=> state_r == 3'h0)
    else $error("trigger did not clear");
  chk_sw_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sw_disarm && !arm_set && !trig_end |=> $stable(state_r))
    else $error("disarm changed state");
  chk_no_resv: assert property (@(posedge ref_clk) disable iff (sys_rst)
    state_r <= 3'h4) else $error("reserved state");
endmodule

// [dtsr_top.sv]
// debug status, line info and trace buffer readout
// assumes register strobes are one-cycle, synchronous to ref_clk
// Contract
// - full flag sets after 64 lines since arming; then all lines valid
// - full flag cleared by arm write or power-on reset only
// - external tag hit after arming sets flag; arm write clears it
// - sequencer field updates on each state transition while armed
// - software disarm keeps the sequencer field unchanged
// - internal trigger end returns sequencer field to zero
// - arming forces the sequencer field to 001
// - encoding 000 disarmed, 001-011 states, 100 final, rest reserved
// - main processor size and direction bits, detail mode only
// - coprocessor size and direction bits, detail mode only
// - opcode fetch bit per processor in detail mode
// - coprocessor real access bit in detail mode
// - arm locks buffer; aligned word write while disarmed unlocks
// - only aligned word reads return data; others zero, no advance
// - oldest first; line count never decreases while reading
// - after session pointer goes to oldest entry
// - aligned word write to high port resets pointer to oldest
`timescale 1ns/10ps
`include "dtsr_cfg.svh"
module dtsr_top #(
  parameter int LINES = `DTSR_LINES,
  parameter int AW = 6
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic por_rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic reg_word,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic trace_en,
  input wire logic detail_mode,
  input wire logic secured,
  input wire logic cap_valid,
  input wire logic [63:0] cap_data,
  input wire logic main_cpu_byte_size_bit,
  input wire logic main_cpu_read_bit,
  input wire logic main_cpu_opfetch_bit,
  input wire logic coproc_real_access_bit,
  input wire logic coproc_byte_size_bit,
  input wire logic coproc_read_bit,
  input wire logic coproc_opfetch_bit,
  input wire logic [1:0] external_tag_inputs,
  input wire logic seq_adv,
  input wire logic trig_end,
  output logic [2:0] sequencer_state_field,
  output logic armed
);
  dtsr_pkg::dtsr_phase_t phase_r;
  logic trace_full_flag_r;
  logic external_tag_hit_flag_r;
  logic [6:0] valid_line_count_r;
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [1:0] word_r;
  logic unlocked_r;
  logic [7:0] info_r;
  logic [71:0] line;
  logic [7:0] info_nxt;
  logic [AW-1:0] oldest;
  logic ctrl_wr, arm_set, sw_disarm, aligned, can_read;
  logic tb_rd, tb_rd_ok, tbh_wr, tb_wr;
  logic [15:0] tb_word;

  initial begin
    if (LINES != (1 << AW) || LINES > 64) $error("bad trace depth");
  end

  assign ctrl_wr = reg_wr && reg_addr == `DTSR_CTRL_OFS;
  assign arm_set = ctrl_wr && reg_wdata[`DTSR_ARM_BIT];
  assign sw_disarm = ctrl_wr && !reg_wdata[`DTSR_ARM_BIT] && armed;
  assign aligned = reg_word && !reg_addr[0];
  assign tb_rd = reg_rd && reg_addr >= `DTSR_TBH_OFS &&
                 reg_addr < `DTSR_TBL_OFS + 8'h2;
  assign tbh_wr = reg_wr && aligned && reg_addr == `DTSR_TBH_OFS;
  assign tb_wr = reg_wr && aligned && (reg_addr == `DTSR_TBH_OFS ||
                 reg_addr == `DTSR_TBL_OFS);
  // reader obligations folded into a gate: data only when permitted
  assign can_read = !armed && trace_en && !secured && unlocked_r;
  assign tb_rd_ok = tb_rd && aligned && can_read;
  assign armed = phase_r == dtsr_pkg::DTSR_ARMED;
  // oldest entry is line zero unless the store wrapped
  assign oldest = trace_full_flag_r ? wr_ptr_r : '0;

  dtsr_seq u_seq (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .arm_set(arm_set),
    .sw_disarm(sw_disarm),
    .trig_end(trig_end && armed),
    .adv(seq_adv && armed),
    .state_r(sequencer_state_field)
  );

  always_comb begin
    info_nxt = 8'h00;
    if (detail_mode) begin
      info_nxt[6] = main_cpu_byte_size_bit;
      info_nxt[5] = main_cpu_read_bit;
      info_nxt[4] = main_cpu_opfetch_bit;
      info_nxt[3] = coproc_real_access_bit;
      info_nxt[2] = coproc_byte_size_bit;
      info_nxt[1] = coproc_read_bit;
      info_nxt[0] = coproc_opfetch_bit;
    end
  end

  dtsr_mem #(.LINES(LINES), .AW(AW)) u_mem (
    .ref_clk(ref_clk),
    .wr_en(cap_valid && armed),
    .wr_addr(wr_ptr_r),
    .wr_data({info_nxt, cap_data}),
    .rd_addr(rd_ptr_r),
    .rd_data(line)
  );

  // session phase
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      phase_r <= dtsr_pkg::DTSR_IDLE;
    end else if (arm_set) begin
      phase_r <= dtsr_pkg::DTSR_ARMED;
    end else if (armed && (sw_disarm || trig_end)) begin
      phase_r <= dtsr_pkg::DTSR_DONE;
    end
  end

  // full flag lives on power-on reset only, ordinary reset leaves it
  always_ff @(posedge ref_clk) begin
    if (por_rst) begin
      trace_full_flag_r <= 1'b0;
    end else if (arm_set) begin
      trace_full_flag_r <= 1'b0;
    end else if (armed && cap_valid && valid_line_count_r == 7'(LINES - 1))
    begin
      trace_full_flag_r <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      external_tag_hit_flag_r <= 1'b0;
    end else if (arm_set) begin
      external_tag_hit_flag_r <= 1'b0;
    end else if (armed && |external_tag_inputs) begin
      external_tag_hit_flag_r <= 1'b1;
    end
  end

  // capture side: count saturates at depth, reads never touch it
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      valid_line_count_r <= 7'h00;
      wr_ptr_r <= '0;
    end else if (arm_set) begin
      valid_line_count_r <= 7'h00;
      wr_ptr_r <= '0;
    end else if (armed && cap_valid) begin
      wr_ptr_r <= wr_ptr_r + 1'b1;
      if (valid_line_count_r != 7'(LINES)) begin
        valid_line_count_r <= valid_line_count_r + 7'h01;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      unlocked_r <= 1'b0;
    end else if (arm_set) begin
      unlocked_r <= 1'b0;
    end else if (tb_wr && !armed) begin
      unlocked_r <= 1'b1;
    end
  end

  // read pointer and word index within the 64-bit line
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_ptr_r <= '0;
      word_r <= 2'h0;
    end else if (armed && (sw_disarm || trig_end)) begin
      rd_ptr_r <= trace_full_flag_r || (cap_valid &&
                  valid_line_count_r == 7'(LINES - 1)) ?
                  wr_ptr_r + AW'(cap_valid) : '0;
      word_r <= 2'h0;
    end else if (tbh_wr) begin
      rd_ptr_r <= oldest;
      word_r <= 2'h0;
    end else if (tb_rd_ok) begin
      word_r <= word_r + 2'h1;
      if (word_r == 2'h3) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  always_comb begin
    case (word_r)
      2'h0: tb_word = line[63:48];
      2'h1: tb_word = line[47:32];
      2'h2: tb_word = line[31:16];
      default: tb_word = line[15:0];
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      info_r <= 8'h00;
    end else if (tb_rd_ok && word_r == 2'h0) begin
      info_r <= line[71:64];
    end
  end

  // read data registered; misaligned or locked trace buffer reads give zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      if (tb_rd) begin
        reg_rdata <= tb_rd_ok ? tb_word : 16'h0000;
      end else if (reg_addr == `DTSR_STATUS_OFS) begin
        reg_rdata <= {8'h00, trace_full_flag_r, external_tag_hit_flag_r,
                      3'b000, sequencer_state_field};
      end else if (reg_addr == `DTSR_INFO_OFS) begin
        reg_rdata <= {8'h00, info_r};
      end else if (reg_addr == `DTSR_CNT_OFS) begin
        reg_rdata <= {9'h000, valid_line_count_r};
      end else if (reg_addr == `DTSR_CTRL_OFS) begin
        reg_rdata <= {8'h00, armed, 7'h00};
      end
    end
  end

  chk_full_set: assert property (@(posedge ref_clk) disable iff (por_rst)
    armed && cap_valid && !arm_set && valid_line_count_r == 7'(LINES - 1)
    |=> trace_full_flag_r) else $error("full flag missed");
  chk_full_clear: assert property (@(posedge ref_clk) disable iff (por_rst)
    arm_set |=> !trace_full_flag_r) else $error("full not cleared");
  chk_ext_hit: assert property (@(posedge ref_clk) disable iff (sys_rst)
    armed && !arm_set && |external_tag_inputs |=> external_tag_hit_flag_r)
    else $error("tag hit lost");
  chk_lock_arm: assert property (@(posedge ref_clk) disable iff (sys_rst)
    arm_set |=> !unlocked_r [*2]) else $error("buffer not locked");
  chk_bad_read: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tb_rd && !aligned && !reg_wr |=> reg_rdata == 16'h0000 &&
    $stable(rd_ptr_r)) else $error("bad read returned data");
  chk_cnt_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tb_rd_ok |=> valid_line_count_r >= $past(valid_line_count_r))
    else $error("count dropped on read");
  chk_restart: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tbh_wr && !armed && !arm_set |=> rd_ptr_r == $past(oldest) &&
    word_r == 2'h0) else $error("restart missed");
  chk_line_adv: assert property (@(posedge ref_clk) disable iff (sys_rst)
    tb_rd_ok && !tbh_wr && word_r != 2'h3 && !armed |=> $stable(rd_ptr_r))
    else $error("early advance");
  chk_info_detail: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !detail_mode |-> info_nxt == 8'h00)
    else $error("info outside detail");
endmodule

// [tb.sv]
// self-checking bench for the trace status readout block
// assumes dtsr_top and dtsr_host compiled before it
`timescale 1ns/10ps
module tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic por_rst = 1'b1;
  logic reg_wr, reg_rd, reg_word;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, got;
  logic trace_en = 1'b1;
  logic detail_mode = 1'b1;
  logic secured = 1'b0;
  logic cap_valid = 1'b0;
  logic seq_adv = 1'b0;
  logic trig_end = 1'b0;
  logic [63:0] cap_data = 64'h0;
  logic [6:0] info = 7'h00;
  logic [1:0] ext_tag = 2'h0;
  logic [2:0] sequencer_state_field;
  logic armed;
  logic [63:0] lines [$];
  logic [6:0] infos [$];
  int fails = 0;
  int samples_checked = 0;
  int cyc = 0;
  always #12.5 ref_clk = ~ref_clk;
  dtsr_host u_dtsr_host (.ref_clk(ref_clk), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_word(reg_word),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
  dtsr_top u_dtsr_top (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .por_rst(por_rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_word(reg_word), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .trace_en(trace_en),
    .detail_mode(detail_mode), .secured(secured),
    .cap_valid(cap_valid), .cap_data(cap_data),
    .main_cpu_byte_size_bit(info[6]), .main_cpu_read_bit(info[5]),
    .main_cpu_opfetch_bit(info[4]), .coproc_real_access_bit(info[3]),
    .coproc_byte_size_bit(info[2]), .coproc_read_bit(info[1]),
    .coproc_opfetch_bit(info[0]), .external_tag_inputs(ext_tag),
    .seq_adv(seq_adv), .trig_end(trig_end),
    .sequencer_state_field(sequencer_state_field), .armed(armed));
  // info bits only mean something in detail mode
  function automatic logic [6:0] exp_info(input logic [6:0] i,
                                          input logic d);
    return d ? i : 7'h00;
  endfunction
  task automatic test_done();
    $display("checked %0d failed %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1'b1;
    @(negedge ref_clk);
    s = 1'b0;
  endtask
  // bits 5:3 unspecified, masked off
  task automatic st(input logic [7:0] e);
    u_dtsr_host.rd(8'h21, 1'b0, got);
    chk({8'h00, e}, got & 16'h00C7);
    chk({13'h0000, e[2:0]}, {13'h0000, sequencer_state_field});
  endtask
  task automatic cnt(input logic [15:0] e);
    u_dtsr_host.rd(8'h23, 1'b0, got);
    chk(e, got & 16'h007F);
  endtask
  task automatic cap(input int n);
    repeat (n) begin
      @(negedge ref_clk);
      cap_valid = 1'b1;
      cap_data = {$urandom, $urandom};
      info = 7'($urandom);
      lines.push_back(cap_data);
      infos.push_back(exp_info(info, detail_mode));
      @(negedge ref_clk);
      cap_valid = 1'b0;
    end
  endtask
  task automatic rdline(input int k);
    for (int i = 0; i < 4; i++) begin
      u_dtsr_host.rd(8'h24, 1'b1, got);
      chk(lines[k][63-16*i -: 16], got);
      if (i == 0) begin
        u_dtsr_host.rd(8'h22, 1'b0, got);
        chk(16'(infos[k]), got);
      end
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc > 20000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    void'($urandom(62));
    repeat (4) @(negedge ref_clk);
    sys_rst = 1'b0;
    por_rst = 1'b0;
    st(8'h00);
    $display("reset test done");
    u_dtsr_host.wr(8'h20, 16'h0080, 1'b0);
    st(8'h01);
    chk(16'h0001, {15'h0000, armed});
    for (int i = 2; i <= 5; i++) begin
      pulse(seq_adv);
      st(8'(i > 4 ? 4 : i));
    end
    @(negedge ref_clk);
    ext_tag = 2'h2;
    @(negedge ref_clk);
    ext_tag = 2'h0;
    st(8'h44);
    cap(5);
    u_dtsr_host.wr(8'h20, 16'h0000, 1'b0);
    st(8'h44);
    chk(16'h0000, {15'h0000, armed});
    cnt(16'h0005);
    $display("sequencer test done");
    // still locked from arming, then unlocked
    u_dtsr_host.rd(8'h24, 1'b1, got);
    chk(16'h0000, got);
    u_dtsr_host.wr(8'h24, 16'h0000, 1'b1);
    u_dtsr_host.rd(8'h24, 1'b0, got);
    chk(16'h0000, got);
    u_dtsr_host.rd(8'h25, 1'b1, got);
    chk(16'h0000, got);
    rdline(0);
    rdline(1);
    u_dtsr_host.wr(8'h24, 16'h0000, 1'b1);
    for (int k = 0; k < 5; k++) begin
      rdline(k);
    end
    cnt(16'h0005);
    for (int m = 0; m < 2; m++) begin
      secured = (m == 0);
      trace_en = (m != 0);
      u_dtsr_host.rd(8'h24, 1'b1, got);
      chk(16'h0000, got);
    end
    secured = 1'b0;
    trace_en = 1'b1;
    $display("readout test done");
    // overflow with detail mode off: info must read zero
    detail_mode = 1'b0;
    lines.delete();
    infos.delete();
    u_dtsr_host.wr(8'h20, 16'h0080, 1'b0);
    st(8'h01);
    cap(63);
    st(8'h01);
    cap(7);
    st(8'h81);
    pulse(trig_end);
    st(8'h80);
    cnt(16'h0040);
    u_dtsr_host.wr(8'h26, 16'h0000, 1'b1);
    rdline(6);
    rdline(7);
    pulse(sys_rst);
    st(8'h80);
    pulse(por_rst);
    st(8'h00);
    $display("overflow test done");
    test_done();
  end
endmodule
